//--- common/sadc_pkg.sv
// constants and types for the sar adc control and status block
package sadc_pkg;
    // special-function register map
    localparam logic [7:0] SFR_BUSY_ADDR  = 8'hF5;
    localparam logic [7:0] SFR_CTRL_ADDR  = 8'hD8;
    localparam logic [7:0] SFR_TIME_ADDR  = 8'hEF;
    localparam logic [7:0] SFR_RDATL_ADDR = 8'hD9;
    localparam logic [7:0] SFR_RDATH_ADDR = 8'hDA;
    localparam logic [7:0] BUSY_RESET     = 8'h00;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] TIME_RESET     = 8'h00;
    // field positions
    localparam int BUSY_BIT   = 7;
    localparam int DMA_BIT    = 6;
    localparam int CONT_BIT   = 5;
    localparam int SINGLE_CONVERSION_REQUEST_BIT  = 4;
    localparam int CAL_BIT    = 7;
    // converter sizing and timing
    localparam int RES_BITS   = 12;
    localparam logic [3:0] CH_STOP     = 4'hF;
    localparam logic [3:0] SAR_STEPS   = 4'hC;
    localparam logic [2:0] SYNC_CYCLES = 3'h1;
    localparam logic [3:0] CAL_CYCLES  = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SYNC   = 3'b001,
        ST_TRACK  = 3'b010,
        ST_CONV   = 3'b011,
        ST_LATCH  = 3'b100,
        ST_CAL    = 3'b101,
        ST_FETCH  = 3'b110
    } sadc_state_t;

    // sfr bus request from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sadc_sfr_req_t;

    // analog front-end controls
    typedef struct packed {
        logic       track_a;
        logic       track_b;
        logic [3:0] chan;
        logic [11:0] dac_code;
    } sadc_afe_t;
endpackage

//--- dv/tb.sv
// self-checking testbench for the sar adc control and status block
`timescale 1ns/1ps
`default_nettype none
module tb
    import sadc_pkg::*;
;
    logic          mclk;
    logic          rst_b;
    sadc_sfr_req_t sfr_req;
    logic [7:0]    sfr_rdata_r;
    logic          cmp_hi;
    sadc_afe_t     afe_r;
    logic          dma_req_r;
    logic          dma_ack;
    logic [3:0]    dma_chan;
    logic [11:0]   result_r;
    logic          done_r;
    logic [11:0]   vin;
    logic [7:0]    rd_v;
    logic          tracked;
    int            bad_count;
    int            compares;
    int            cycles;
    int            dur [4];
    localparam logic [11:0] VT [4] = '{12'hA5C, 12'h000, 12'hFFF, 12'h3C1};

    sadc_ctrl u_sadc_ctrl (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .sfr_req     (sfr_req),
        .sfr_rdata_r (sfr_rdata_r),
        .cmp_hi      (cmp_hi),
        .afe_r       (afe_r),
        .dma_req_r   (dma_req_r),
        .dma_ack     (dma_ack),
        .dma_chan    (dma_chan),
        .result_r    (result_r),
        .done_r      (done_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, comparator model, track monitor and hang guard
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        cmp_hi <= (afe_r.dac_code > vin); // trial above input drops the bit
        if (afe_r.track_a === 1'b1 && afe_r.track_b === 1'b1) tracked <= 1'b1;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            $display("CHECK FAILED at %0t: run too long", $time);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // access tasks
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        sfr_req.wr = 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        sfr_req.rd = 1'b0;
        d = sfr_rdata_r;
    endtask
    task automatic wait_done(output int n);
        n = 0;
        while (done_r !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 300) cmp(16'h0, 16'h1, "no done");
    endtask
    task automatic dma_give(input logic [3:0] ch);
        int k;
        k = 0;
        while (dma_req_r !== 1'b1 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        cmp(k < 300, 1'b1, "no id request");
        dma_chan = ch;
        dma_ack = 1'b1;
        @(negedge mclk);
        dma_ack = 1'b0;
    endtask
    // waits out one conversion and checks result, channel and phases
    task automatic finish_conv(input logic [3:0] ch, output int n);
        wait_done(n);
        cmp(result_r, vin, "result at done");
        cmp(afe_r.chan, ch, "converted channel");
        cmp(tracked, 1'b1, "no track phase");
        cmp(afe_r.track_a | afe_r.track_b, 1'b0, "not in hold");
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h00, "busy after done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        sfr_req = '0;
        cmp_hi = 1'b0;
        dma_ack = 1'b0;
        dma_chan = 4'h0;
        vin = 12'h000;
        tracked = 1'b0;
        rst_b = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, BUSY_RESET, "status reset");
        sfr_rd(SFR_CTRL_ADDR, rd_v);
        cmp(rd_v, CTRL_RESET, "control reset");
        $display("test reset done");
        // single conversions with each acquisition length
        for (int i = 0; i < 4; i++) begin
            sfr_wr(SFR_TIME_ADDR, 8'(i << 2));
            vin = VT[i];
            tracked = 1'b0;
            sfr_wr(SFR_CTRL_ADDR, 8'h15 + 8'(i));
            repeat (3) @(negedge mclk);
            sfr_rd(SFR_BUSY_ADDR, rd_v);
            cmp(rd_v, 8'h80, "busy during conversion");
            finish_conv(4'h5 + 4'(i), dur[i]);
            if (i > 0) cmp(dur[i] - dur[i-1], 16'h1, "acquisition step");
        end
        sfr_rd(SFR_CTRL_ADDR, rd_v);
        cmp(rd_v, 8'h08, "single bit cleared");
        sfr_rd(SFR_RDATL_ADDR, rd_v);
        cmp(rd_v, VT[3][7:0], "result low byte");
        sfr_rd(SFR_RDATH_ADDR, rd_v);
        cmp(rd_v[3:0], VT[3][11:8], "result high nibble");
        sfr_wr(SFR_BUSY_ADDR, 8'h80);
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h00, "status write ignored");
        sfr_rd(8'h80, rd_v);
        cmp(rd_v, 8'h00, "unmapped read");
        // divided adc clock stretches the sync, track and conversion steps of the sequence
        sfr_wr(SFR_TIME_ADDR, 8'h10);
        vin = 12'h2D7;
        tracked = 1'b0;
        sfr_wr(SFR_CTRL_ADDR, 8'h02);
        repeat (4) @(negedge mclk);
        sfr_wr(SFR_CTRL_ADDR, 8'h12);
        repeat (3) @(negedge mclk);
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h80, "busy while divided");
        finish_conv(4'h2, dur[1]);
        cmp(dur[1] >= dur[0] + 13 && dur[1] <= dur[0] + 14, 1'b1, "divided timing");
        $display("test single done");
        // calibration holds busy then clears it
        sfr_wr(SFR_TIME_ADDR, 8'h80);
        repeat (2) @(negedge mclk);
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h80, "busy in calibration");
        for (int k = 0; k < 60 && rd_v != 8'h00; k++) sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h00, "busy after calibration");
        sfr_rd(SFR_TIME_ADDR, rd_v);
        cmp(rd_v[CAL_BIT], 1'b0, "calibration bit cleared");
        $display("test calibration done");
        // dma: channel from memory id, then stop code
        vin = 12'h5A5;
        tracked = 1'b0;
        sfr_wr(SFR_CTRL_ADDR, 8'h67);
        dma_give(4'h3);
        finish_conv(4'h3, dur[0]);
        dma_give(CH_STOP);
        repeat (4) @(negedge mclk);
        cmp(dma_req_r, 1'b0, "request after stop");
        sfr_rd(SFR_BUSY_ADDR, rd_v);
        cmp(rd_v, 8'h00, "busy after stop");
        sfr_rd(SFR_CTRL_ADDR, rd_v);
        cmp(rd_v[CONT_BIT], 1'b0, "continuous cleared");
        $display("test dma done");
        stop_test();
    end
endmodule
`default_nettype wire

//--- hdl/sadc_ctrl.sv
// sar adc control, sequencing and status registers
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire sadc_sfr_req_t sfr_req,
    output logic [7:0]         sfr_rdata_r,
    input  wire logic          cmp_hi,
    output sadc_afe_t          afe_r,
    output logic               dma_req_r,
    input  wire logic          dma_ack,
    input  wire logic [3:0]    dma_chan,
    output logic [11:0]        result_r,
    output logic               done_r
);
    ////////////////////////////////////////////////////////////////
    // registers and decode
    sadc_state_t state_r, state_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  time_r;
    logic        busy_r;
    logic [3:0]  cnt_r;
    logic [11:0] sar_r;
    logic [11:0] bit_r;
    logic        tick;

    wire wr_ctrl = sfr_req.wr && (sfr_req.addr == SFR_CTRL_ADDR);
    wire wr_time = sfr_req.wr && (sfr_req.addr == SFR_TIME_ADDR);
    wire dma_on  = ctrl_r[DMA_BIT];
    wire start   = ctrl_r[SINGLE_CONVERSION_REQUEST_BIT] || ctrl_r[CONT_BIT];
    wire [3:0] acq_len = {2'b00, time_r[3:2]} + 4'h1;
    wire [1:0] div_sel = time_r[5:4];
    wire step    = tick;
    wire last_step = (bit_r == 12'h001);
    wire conv_step = step && (state_r == ST_CONV);
    // trial decision: drop the bit if the comparator says too high, try the next
    wire [11:0] sar_try = (cmp_hi ? sar_r & ~bit_r : sar_r) | (bit_r >> 1);
    // the last step still applies its decision, so the latch sees the final code
    wire [11:0] sar_nxt = conv_step ? sar_try :
                          (state_nxt != state_r) ? 12'h800 : sar_r;
    // status read: busy in bit 7, reserved bits forced to zero
    wire [7:0] busy_view = {busy_r, 7'h00};
    wire [7:0] rd_mux =
        (sfr_req.addr == SFR_BUSY_ADDR)  ? busy_view :
        (sfr_req.addr == SFR_CTRL_ADDR)  ? ctrl_r :
        (sfr_req.addr == SFR_TIME_ADDR)  ? time_r :
        (sfr_req.addr == SFR_RDATL_ADDR) ? result_r[7:0] :
        (sfr_req.addr == SFR_RDATH_ADDR) ? {4'h0, result_r[11:8]} : 8'h00;

    sadc_tick u_tick (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .div_sel (div_sel),
        .tick_r  (tick)
    );

    ////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (time_r[CAL_BIT])
                    state_nxt = ST_CAL;
                else if (start && dma_on)
                    state_nxt = ST_FETCH;
                else if (start)
                    state_nxt = ST_SYNC;
            end
            ST_FETCH: begin
                if (dma_ack)
                    state_nxt = (dma_chan == CH_STOP) ? ST_IDLE : ST_SYNC;
            end
            ST_SYNC:  if (step && cnt_r == 4'h0) state_nxt = ST_TRACK;
            ST_TRACK: if (step && cnt_r == 4'h0) state_nxt = ST_CONV;
            ST_CONV:  if (step && last_step) state_nxt = ST_LATCH;
            ST_LATCH: state_nxt = ST_IDLE;
            ST_CAL:   if (step && cnt_r == 4'h0) state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // state, counters and sar
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            sar_r   <= 12'h000;
            bit_r   <= 12'h800;
        end else begin
            state_r <= state_nxt;
            sar_r   <= sar_nxt;
            if (conv_step) begin
                // move the trial bit down, also on the step that leaves conversion
                bit_r <= bit_r >> 1;
            end else if (state_nxt != state_r) begin
                case (state_nxt)
                    ST_SYNC:  cnt_r <= {1'b0, SYNC_CYCLES} - 4'h1;
                    ST_TRACK: cnt_r <= acq_len - 4'h1;
                    ST_CAL:   cnt_r <= CAL_CYCLES;
                    default:  cnt_r <= 4'h0;
                endcase
                bit_r <= 12'h800;
            end else if (step && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // busy, result and completion strobe change together at the end of a conversion; calibration end clears busy alone
    wire finish = (state_r == ST_LATCH) ||
                  (state_r == ST_CAL && state_nxt == ST_IDLE);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r   <= 1'b0;
            result_r <= 12'h000;
            done_r   <= 1'b0;
        end else begin
            done_r <= (state_r == ST_LATCH);
            if (state_r == ST_LATCH)
                result_r <= sar_r;
            if (finish)
                busy_r <= 1'b0;
            else if (state_nxt == ST_SYNC || state_nxt == ST_CAL)
                busy_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // control and timing registers; status register takes no write
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RESET;
            time_r <= TIME_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_r <= sfr_req.wdata;
            else if (state_r == ST_LATCH)
                ctrl_r[SINGLE_CONVERSION_REQUEST_BIT] <= 1'b0;
            else if (state_r == ST_FETCH && dma_ack && dma_chan == CH_STOP)
                ctrl_r[CONT_BIT] <= 1'b0;
            if (wr_time)
                time_r <= sfr_req.wdata;
            else if (state_r == ST_CAL && state_nxt == ST_IDLE)
                time_r[CAL_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data, front end and dma fetch request
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata_r <= 8'h00;
            afe_r       <= '0;
            dma_req_r   <= 1'b0;
        end else begin
            sfr_rdata_r      <= sfr_req.rd ? rd_mux : 8'h00;
            afe_r.track_a    <= (state_nxt == ST_TRACK);
            afe_r.track_b    <= (state_nxt == ST_TRACK);
            afe_r.dac_code   <= sar_nxt; // comparator sees the trial held in sar_r
            dma_req_r        <= (state_nxt == ST_FETCH) && !dma_ack;
            if (state_r == ST_FETCH && dma_ack)
                afe_r.chan <= dma_chan;
            else if (state_r == ST_IDLE && start && !dma_on)
                afe_r.chan <= ctrl_r[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    sequence s_latch_end;
        (state_r == ST_LATCH) ##1 !busy_r;
    endsequence

    a_busy_during_conv: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_CONV || state_r == ST_TRACK) |-> busy_r)
        else $error("busy low during conversion");
    a_busy_self_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_LATCH) |-> s_latch_end)
        else $error("busy not cleared at end");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(sfr_req.rd && sfr_req.addr == SFR_BUSY_ADDR) |-> sfr_rdata_r[6:0] == 7'h00)
        else $error("reserved status bits nonzero");
    a_status_read: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(sfr_req.rd && sfr_req.addr == SFR_BUSY_ADDR) |-> sfr_rdata_r[7] == $past(busy_r))
        else $error("status read mismatch");
    a_track_first: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_SYNC && state_nxt == ST_TRACK) |=> afe_r.track_a && afe_r.track_b)
        else $error("track phase missing");
    a_hold_in_conv: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_CONV) |-> !afe_r.track_a)
        else $error("switches not in hold");
    a_single_conversion_request_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_LATCH && !wr_ctrl) |=> !ctrl_r[SINGLE_CONVERSION_REQUEST_BIT])
        else $error("single request not cleared");
    a_result_busy: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(busy_r) && done_r |-> result_r == $past(sar_r))
        else $error("result not ready when busy falls");
    a_dma_stop: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r == ST_FETCH && dma_ack && dma_chan == CH_STOP) |=> state_r == ST_IDLE)
        else $error("dma stop code ignored");
    a_acq_len: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_r != ST_TRACK) ##1 (state_r == ST_TRACK) |-> cnt_r == acq_len - 4'h1)
        else $error("acquisition length wrong");
endmodule
`default_nettype wire

//--- hdl/sadc_tick.sv
// adc clock divider that paces the sequencer
`timescale 1ns/1ps
`default_nettype none
module sadc_tick
    import sadc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic [1:0] div_sel,
    output logic            tick_r
);
    logic [3:0] cnt_r;
    logic [3:0] limit;

    // divide ratios 1, 2, 4, 8 master clocks per adc clock
    assign limit = (4'h1 << div_sel) - 4'h1;

    // count down, pulse once per adc clock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (cnt_r == 4'h0);
            cnt_r  <= (cnt_r == 4'h0) ? limit : cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire
